// ---- logic/pss_consts.svh ----
// Constants of the pump start supervisor: offsets, fields, resets, timing.
// Assumes a 40 MHz clock and timers counted in tenths of a second.
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_CLK_NS 25
`define PSS_TICK_NS 100000000
`define PSS_TICK_CYCLES (`PSS_TICK_NS / `PSS_CLK_NS)
// Register offsets
`define PSS_A_CTRL 6'h00
`define PSS_A_SDLY 6'h04
`define PSS_A_PRE 6'h08
`define PSS_A_POST 6'h0c
`define PSS_A_VALID 6'h10
`define PSS_A_VERIF 6'h14
`define PSS_A_TTS 6'h18
`define PSS_A_TRIPSPD 6'h1c
`define PSS_A_DTIME 6'h20
`define PSS_A_DCYC 6'h24
`define PSS_A_STAT 6'h28
// Control fields
`define PSS_F_LMODE 1:0
`define PSS_B_ADV 2
`define PSS_B_FLOW 3
`define PSS_B_DOUT 4
`define PSS_F_TRIG 11:5
`define PSS_B_CLR 12
// Status word bits
`define PSS_B_RUNOK 0
`define PSS_B_VERIF 1
`define PSS_B_TFLOW 2
`define PSS_B_TSPD 3
`define PSS_B_DERAG 23
// Reset values and limits, lube in seconds, others in tenths
`define PSS_RV_LUBE 10'h00a
`define PSS_LUBE_MAX 10'h258
`define PSS_RV_VERIF 16'h0096
`define PSS_VALID_MAX 16'h2706
`define PSS_VERIF_MAX 16'h09f6
`define PSS_RV_VALID 16'h0064
`define PSS_RV_TTS 16'h0064
`endif

// ---- logic/pss_pkg.sv ----
// Types shared by the pump start supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package pss_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_DELAY, S_RAMP, S_VERIFY, S_RUN, S_TRIP,
    S_DSTOP, S_DOFF, S_DREV, S_DCOAST, S_DFWD
  } pss_state_type;
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pss_bus_type;
  typedef struct packed {
    logic slu;
    logic timed;
    logic hipow;
  } pss_trig_type;
endpackage

// ---- logic/pss_timer.sv ----
// Down counter in tenths of a second, one per supervision timer.
// Assumes tick_i is a one-cycle pulse from the common prescaler.
`timescale 1ns/100ps
module pss_timer #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  import pss_pkg::*;
  logic [W-1:0] cnt_reg;

  // Load wins over the tick so a restart never loses a count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_reg <= value_i;
      end else if (tick_i && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign done_o = (cnt_reg == '0);

  load_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && load_i) |=> cnt_reg == $past(value_i))
    else $error("timer did not take its load value");
  count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ce_i && (load_i || tick_i)) |=> $stable(cnt_reg))
    else $error("timer moved without tick or load");
endmodule

// ---- logic/pss_supervisor.sv ----
// Pump start supervisor: lube output, start delay, flow confirmation,
// minimum speed trips and derag sequencing. Assumes a 40 MHz clock,
// speed_i and trig_i from logic on the same clock, the rest from pins.
`timescale 1ns/100ps
`include "pss_consts.svh"
//Contract
//- Extended status bit 23 is set exactly while a derag event runs.
//- Optional digital output follows the active derag status throughout.
//- Derag starts on start, stop, either, input, sequence logic, timer or power.
//- Enabled lube output rises on the run request edge for the pre-lube time; in modes 2 and 3 it stays on while run is requested.
//- Start delay keeps motor stopped; pre-lube while stopped; ramp after delay.
//- Lube mode: 0 off, 1 pre only, 2 pre and run, 3 plus post.
//- Pre-lube time 0 to 600 s, default 10, used only in mode 1.
//- Mode 3 holds lube after stop for post time 0 to 600 s, default 10.
//- Start loads start delay and time-to-speed together; ramp at delay end.
//- After start, run and wait validation time 0.1 to 999 s for flow.
//- After first flow, wait verification time and recheck before normal running.
//- Flow input lost before either window ends trips with flow alarm.
//- Verifying flow status shown while flow monitoring is active.
//- Advanced monitoring trips when speed falls below trip speed in running.
//- Trip when trip speed not reached before maximum time-to-speed expires.
//- Start delay and time-to-speed timers both start at the start command.
//- Start delay not below time-to-speed trips before ramping, motor never runs.
//- Derag: ramp to stop, off delay unless stopped, then reverse and forward pulses.
module pss_supervisor #(
  parameter int TICK_CYCLES = `PSS_TICK_CYCLES,
  parameter int SPD_W = 16,
  parameter logic [15:0] VALID_RST = `PSS_RV_VALID,
  parameter logic [15:0] TTS_RST = `PSS_RV_TTS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire pss_pkg::pss_bus_type bus_i,
  output logic [31:0] rdata_o,
  input wire logic run_req_i,
  input wire logic flow_ok_i,
  input wire logic derag_din_i,
  input wire pss_pkg::pss_trig_type trig_i,
  input wire logic [SPD_W-1:0] speed_i,
  output logic run_o,
  output logic rev_o,
  output logic coast_o,
  output logic lube_o,
  output logic derag_dout_o,
  output logic verifying_o,
  output logic [31:0] ext_status_o
);
  import pss_pkg::*;
  localparam int PW = $clog2(TICK_CYCLES);
  localparam int T_DLY = 0;
  localparam int T_TTS = 1;
  localparam int T_FLOW = 2;
  localparam int T_LUBE = 3;
  localparam int T_DRG = 4;

  generate
    if (TICK_CYCLES < 2 || SPD_W < 1 || SPD_W > 32) begin : g_bad
      $error("pss_supervisor: unsupported parameter values");
    end
  endgenerate

  pss_state_type state_reg, state_next;
  logic [2:0] meta_reg, sync_reg;
  logic run_d_reg, din_d_reg, arm_reg;
  logic [PW-1:0] pre_reg;
  logic tick_reg;
  logic [1:0] lmode_reg;
  logic adv_reg, flow_en_reg, dout_en_reg, clr_reg;
  logic [6:0] trig_en_reg;
  logic [9:0] pre_s_reg, post_s_reg;
  logic [15:0] sdly_reg, valid_reg, verif_reg, tts_reg, drun_reg, doff_reg;
  logic [SPD_W-1:0] tspd_reg;
  logic [3:0] dcyc_reg, cyc_reg;
  logic drg_pend_reg, reached_reg, coast_fwd_reg;
  logic pre_on_reg, post_on_reg, post_wait_reg;
  logic tflow_reg, tspd_trip_reg;
  logic [4:0] tmr_load, tmr_done;
  logic [15:0] tmr_val [0:4];
  logic run_s, flow_s, din_s, run_rise, run_fall, din_rise;
  logic start_go, in_derag, drg_start, run_state, spd_fail, trig_any;
  logic lube_ld, spd_low;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] hi);
    logic [15:0] r;
    r = (v > hi) ? hi : v;
    clamp16 = (r == 16'h0000) ? 16'h0001 : r;
  endfunction

  // Pin inputs pass two flops; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else if (ce_i) begin
      meta_reg <= {derag_din_i, flow_ok_i, run_req_i};
      sync_reg <= meta_reg;
    end
  end

  assign run_s = sync_reg[0];
  assign flow_s = sync_reg[1];
  assign din_s = sync_reg[2];
  assign run_rise = run_s && !run_d_reg;
  assign run_fall = !run_s && run_d_reg;
  assign din_rise = din_s && !din_d_reg;

  // Edge history and start arming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_d_reg <= 1'b0;
      din_d_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else if (ce_i) begin
      run_d_reg <= run_s;
      din_d_reg <= din_s;
      if (run_rise) begin
        arm_reg <= 1'b1;
      end else if (run_fall || state_next == S_TRIP) begin
        arm_reg <= 1'b0;
      end
    end
  end

  // Shared 0.1 s tick; restarted on start so timers stay aligned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= '0;
      tick_reg <= 1'b0;
    end else if (ce_i) begin
      tick_reg <= 1'b0;
      if (start_go) begin
        pre_reg <= '0;
      end else if (pre_reg == PW'(TICK_CYCLES - 1)) begin
        pre_reg <= '0;
        tick_reg <= 1'b1;
      end else begin
        pre_reg <= pre_reg + 1'b1;
      end
    end
  end

  // Register writes; out-of-range times are clamped, not refused
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lmode_reg <= 2'h0;
      adv_reg <= 1'b0;
      flow_en_reg <= 1'b0;
      dout_en_reg <= 1'b0;
      trig_en_reg <= 7'h00;
      clr_reg <= 1'b0;
      sdly_reg <= 16'h0000;
      pre_s_reg <= `PSS_RV_LUBE;
      post_s_reg <= `PSS_RV_LUBE;
      valid_reg <= VALID_RST;
      verif_reg <= `PSS_RV_VERIF;
      tts_reg <= TTS_RST;
      tspd_reg <= '0;
      drun_reg <= 16'h0001;
      doff_reg <= 16'h0001;
      dcyc_reg <= 4'h1;
    end else if (ce_i) begin
      clr_reg <= 1'b0;
      if (bus_i.wr) begin
        unique case (bus_i.addr)
          `PSS_A_CTRL: begin
            lmode_reg <= bus_i.wdata[`PSS_F_LMODE];
            adv_reg <= bus_i.wdata[`PSS_B_ADV];
            flow_en_reg <= bus_i.wdata[`PSS_B_FLOW];
            dout_en_reg <= bus_i.wdata[`PSS_B_DOUT];
            trig_en_reg <= bus_i.wdata[`PSS_F_TRIG];
            clr_reg <= bus_i.wdata[`PSS_B_CLR];
          end
          `PSS_A_SDLY: sdly_reg <= bus_i.wdata[15:0];
          `PSS_A_PRE: pre_s_reg <= (bus_i.wdata[9:0] > `PSS_LUBE_MAX) ? `PSS_LUBE_MAX : bus_i.wdata[9:0];
          `PSS_A_POST: post_s_reg <= (bus_i.wdata[9:0] > `PSS_LUBE_MAX) ? `PSS_LUBE_MAX : bus_i.wdata[9:0];
          `PSS_A_VALID: valid_reg <= clamp16(bus_i.wdata[15:0], `PSS_VALID_MAX);
          `PSS_A_VERIF: verif_reg <= clamp16(bus_i.wdata[15:0], `PSS_VERIF_MAX);
          `PSS_A_TTS: tts_reg <= bus_i.wdata[15:0];
          `PSS_A_TRIPSPD: tspd_reg <= bus_i.wdata[SPD_W-1:0];
          `PSS_A_DTIME: begin
            drun_reg <= bus_i.wdata[15:0];
            doff_reg <= bus_i.wdata[31:16];
          end
          `PSS_A_DCYC: dcyc_reg <= bus_i.wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_o <= 32'h0000_0000;
      if (bus_i.rd) begin
        unique case (bus_i.addr)
          `PSS_A_CTRL: rdata_o <= {19'h0, 1'b0, trig_en_reg, dout_en_reg, flow_en_reg, adv_reg, lmode_reg};
          `PSS_A_SDLY: rdata_o <= {16'h0, sdly_reg};
          `PSS_A_PRE: rdata_o <= {22'h0, pre_s_reg};
          `PSS_A_POST: rdata_o <= {22'h0, post_s_reg};
          `PSS_A_VALID: rdata_o <= {16'h0, valid_reg};
          `PSS_A_VERIF: rdata_o <= {16'h0, verif_reg};
          `PSS_A_TTS: rdata_o <= {16'h0, tts_reg};
          `PSS_A_TRIPSPD: rdata_o <= 32'(tspd_reg);
          `PSS_A_DTIME: rdata_o <= {doff_reg, drun_reg};
          `PSS_A_DCYC: rdata_o <= {28'h0, dcyc_reg};
          `PSS_A_STAT: rdata_o <= ext_status_o;
          default: rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Supervision timers, one per concern
  assign tmr_val[T_DLY] = sdly_reg;
  assign tmr_val[T_TTS] = tts_reg;
  assign tmr_val[T_FLOW] = (state_reg == S_DELAY) ? valid_reg : verif_reg;
  assign tmr_val[T_LUBE] = post_wait_reg ? ({6'h00, post_s_reg} * 16'h000a) : ({6'h00, pre_s_reg} * 16'h000a);
  assign tmr_val[T_DRG] = (state_next == S_DREV || state_next == S_DFWD) ? drun_reg : doff_reg;
  generate
    for (genvar i = 0; i < 5; i++) begin : g_tmr
      pss_timer #(.W(16)) u_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(tick_reg),
        .load_i(tmr_load[i]),
        .value_i(tmr_val[i]),
        .done_o(tmr_done[i])
      );
    end
  endgenerate

  // Both start timers load together on the start command
  assign start_go = (state_reg == S_IDLE) && (state_next == S_DELAY);
  assign tmr_load[T_DLY] = start_go;
  assign tmr_load[T_TTS] = start_go;
  assign tmr_load[T_FLOW] = (state_next == S_RAMP || state_next == S_VERIFY) && state_next != state_reg;
  assign lube_ld = (run_rise && lmode_reg == 2'h1) || (post_wait_reg && speed_i == '0 && lmode_reg == 2'h3);
  assign tmr_load[T_LUBE] = lube_ld;
  assign tmr_load[T_DRG] = state_next != state_reg && (state_next == S_DOFF || state_next == S_DREV
    || state_next == S_DCOAST || state_next == S_DFWD);

  assign in_derag = state_reg inside {S_DSTOP, S_DOFF, S_DREV, S_DCOAST, S_DFWD};
  assign run_state = state_reg inside {S_DELAY, S_RAMP, S_VERIFY, S_RUN};
  assign drg_start = !in_derag && (state_next == S_DSTOP || state_next == S_DREV);
  assign spd_low = speed_i < tspd_reg;
  assign spd_fail = adv_reg && tmr_done[T_TTS] && !reached_reg;
  assign trig_any = !in_derag && ((trig_en_reg[0] && run_rise) || (trig_en_reg[1] && run_fall)
    || (trig_en_reg[2] && (run_rise || run_fall)) || (trig_en_reg[3] && din_rise)
    || (trig_en_reg[4] && trig_i.slu) || (trig_en_reg[5] && trig_i.timed)
    || (trig_en_reg[6] && trig_i.hipow));

  // Sequencer; trips outrank derag, a stop outranks trips
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (drg_pend_reg) begin
          state_next = (speed_i != '0) ? S_DSTOP : S_DREV;
        end else if (run_s && arm_reg) begin
          state_next = S_DELAY;
        end
      end
      S_DELAY: begin
        if (!run_s) begin
          state_next = S_IDLE;
        end else if (adv_reg && tmr_done[T_TTS]) begin
          state_next = S_TRIP;
        end else if (tmr_done[T_DLY]) begin
          state_next = S_RAMP;
        end
      end
      S_RAMP: begin
        if (!run_s) begin
          state_next = S_IDLE;
        end else if (spd_fail) begin
          state_next = S_TRIP;
        end else if (flow_en_reg && flow_s) begin
          state_next = S_VERIFY;
        end else if (flow_en_reg && tmr_done[T_FLOW]) begin
          state_next = S_TRIP;
        end else if (!flow_en_reg && (reached_reg || !adv_reg)) begin
          state_next = S_RUN;
        end
      end
      S_VERIFY: begin
        if (!run_s) begin
          state_next = S_IDLE;
        end else if (spd_fail || !flow_s) begin
          state_next = S_TRIP;
        end else if (tmr_done[T_FLOW] && (reached_reg || !adv_reg)) begin
          state_next = S_RUN;
        end
      end
      S_RUN: begin
        if (!run_s) begin
          state_next = S_IDLE;
        end else if (adv_reg && spd_low) begin
          state_next = S_TRIP;
        end else if (drg_pend_reg) begin
          state_next = S_DSTOP;
        end
      end
      S_TRIP: if (clr_reg) state_next = S_IDLE;
      S_DSTOP: if (speed_i == '0) state_next = S_DOFF;
      S_DOFF: if (tmr_done[T_DRG]) state_next = S_DREV;
      S_DREV: if (tmr_done[T_DRG]) state_next = S_DCOAST;
      S_DCOAST: if (tmr_done[T_DRG]) state_next = coast_fwd_reg ? S_DFWD : S_DREV;
      S_DFWD: if (tmr_done[T_DRG]) state_next = (cyc_reg <= 4'h1) ? S_IDLE : S_DCOAST;
      default: state_next = S_IDLE;
    endcase
  end

  // State, derag bookkeeping and speed-reached memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      drg_pend_reg <= 1'b0;
      cyc_reg <= 4'h0;
      coast_fwd_reg <= 1'b0;
      reached_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (trig_any) begin
        drg_pend_reg <= 1'b1;
      end else if (drg_start) begin
        drg_pend_reg <= 1'b0;
      end
      if (drg_start) begin
        cyc_reg <= (dcyc_reg == 4'h0) ? 4'h1 : dcyc_reg;
      end else if (state_reg == S_DFWD && state_next == S_DCOAST) begin
        cyc_reg <= cyc_reg - 1'b1;
      end
      if (state_next == S_DCOAST && state_reg != S_DCOAST) begin
        coast_fwd_reg <= (state_reg == S_DREV);
      end
      if (start_go) begin
        reached_reg <= 1'b0;
      end else if (run_state && !spd_low) begin
        reached_reg <= 1'b1;
      end
    end
  end

  // Lube phases: pre in mode 1 only, post waits for standstill
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_on_reg <= 1'b0;
      post_on_reg <= 1'b0;
      post_wait_reg <= 1'b0;
    end else if (ce_i) begin
      if (run_rise && lmode_reg == 2'h1) begin
        pre_on_reg <= 1'b1;
      end else if (pre_on_reg && tmr_done[T_LUBE]) begin
        pre_on_reg <= 1'b0;
      end
      if (run_rise) begin
        post_wait_reg <= 1'b0;
        post_on_reg <= 1'b0;
      end else if (lmode_reg == 2'h3 && run_state && state_next == S_IDLE) begin
        post_wait_reg <= 1'b1;
      end else if (post_wait_reg && lube_ld) begin
        post_wait_reg <= 1'b0;
        post_on_reg <= 1'b1;
      end else if (post_on_reg && tmr_done[T_LUBE]) begin
        post_on_reg <= 1'b0;
      end
    end
  end

  // Trip causes; a new trip wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tflow_reg <= 1'b0;
      tspd_trip_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_next == S_TRIP && state_reg != S_TRIP) begin
        tflow_reg <= !spd_fail && !(state_reg == S_RUN) && !(state_reg == S_DELAY);
        tspd_trip_reg <= spd_fail || state_reg == S_RUN || state_reg == S_DELAY;
      end else if (clr_reg && state_reg == S_TRIP) begin
        tflow_reg <= 1'b0;
        tspd_trip_reg <= 1'b0;
      end
    end
  end

  // Outputs follow the next state so pins change with the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_o <= 1'b0;
      rev_o <= 1'b0;
      coast_o <= 1'b0;
      lube_o <= 1'b0;
      derag_dout_o <= 1'b0;
      verifying_o <= 1'b0;
      ext_status_o <= 32'h0000_0000;
    end else if (ce_i) begin
      run_o <= state_next inside {S_RAMP, S_VERIFY, S_RUN, S_DREV, S_DFWD};
      rev_o <= state_next == S_DREV;
      coast_o <= state_next inside {S_DOFF, S_DCOAST};
      lube_o <= (pre_on_reg && lmode_reg == 2'h1) || (lmode_reg[1] && (run_s || run_state))
        || (lmode_reg == 2'h3 && (post_on_reg || post_wait_reg));
      derag_dout_o <= dout_en_reg && (state_next inside {S_DSTOP, S_DOFF, S_DREV, S_DCOAST, S_DFWD});
      verifying_o <= flow_en_reg && (state_next inside {S_RAMP, S_VERIFY});
      ext_status_o <= 32'h0000_0000;
      ext_status_o[`PSS_B_RUNOK] <= state_next == S_RUN;
      ext_status_o[`PSS_B_VERIF] <= flow_en_reg && (state_next inside {S_RAMP, S_VERIFY});
      ext_status_o[`PSS_B_TFLOW] <= tflow_reg;
      ext_status_o[`PSS_B_TSPD] <= tspd_trip_reg;
      ext_status_o[`PSS_B_DERAG] <= state_next inside {S_DSTOP, S_DOFF, S_DREV, S_DCOAST, S_DFWD};
    end
  end

  derag_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_status_o[`PSS_B_DERAG] == in_derag)
    else $error("derag status bit disagrees with sequencer");
  derag_dout_a: assert property (@(posedge clk_i) disable iff (rst_i)
    derag_dout_o |-> ext_status_o[`PSS_B_DERAG])
    else $error("derag output high outside a derag event");
  derag_trig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && trig_any) |=> (drg_pend_reg || in_derag))
    else $error("derag trigger was lost");
  lube_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && run_rise && lmode_reg != 2'h0) ##1 ce_i |=> lube_o)
    else $error("lube output missing after run request");
  delay_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == S_DELAY) |-> !run_o)
    else $error("motor runs during start delay");
  tts_before_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state_reg == S_DELAY && run_s && adv_reg && tmr_done[T_TTS]) |=> state_reg == S_TRIP && !run_o)
    else $error("start delay outlasting time-to-speed did not trip");
  flow_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state_reg == S_VERIFY && run_s && !flow_s) |=> state_reg == S_TRIP)
    else $error("flow loss during verification did not trip");
  verify_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    verifying_o |-> state_reg inside {S_RAMP, S_VERIFY})
    else $error("verifying flag outside flow monitoring");
  min_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state_reg == S_RUN && run_s && adv_reg && spd_low) |=> state_reg == S_TRIP)
    else $error("low speed in running did not trip");
  start_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && start_go) |=> (tmr_done[T_DLY] == ($past(sdly_reg) == 16'h0000))
      && (tmr_done[T_TTS] == ($past(tts_reg) == 16'h0000)))
    else $error("start timers not loaded together");
endmodule

// ---- bench/pss_drive_model.sv ----
// Far-side model: drive ramp control and flow switch for the supervisor.
// Assumes run_i comes from the supervisor on the same clock.
`timescale 1ns/100ps
module pss_drive_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic flow_en_i,
  output logic [15:0] speed_o,
  output logic flow_o
);
  initial speed_o = 16'h0000;
  // Slow climb while running; coasts to zero at once to keep runs short
  always @(posedge clk_i) begin
    if (!run_i) begin
      speed_o <= 16'h0000;
    end else if (speed_o != 16'hffff) begin
      speed_o <= speed_o + 16'h0001;
    end
  end
  // Switch only closes while water moves
  assign flow_o = flow_en_i & run_i;
endmodule

// ---- bench/test_pump_start_supervisor.sv ----
// Testbench for the pump start supervisor: reset values, derag, lube, trips.
// Assumes the drive model beside it and a four-cycle tick.
`timescale 1ns/100ps
`include "pss_consts.svh"
module test_pump_start_supervisor;
  import pss_pkg::*;
  typedef struct packed {logic [5:0] a; logic [31:0] e;} pss_row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic run_req_i = 1'b0;
  logic flow_en = 1'b0;
  pss_bus_type bus_i = '0;
  pss_trig_type trig_i = '0;
  logic [31:0] rdata_o, ext_status_o, d;
  logic [15:0] speed_i;
  logic flow_ok_i, run_o, rev_o, coast_o, lube_o, derag_dout_o, verifying_o;
  logic [8:0] obs;
  int fails = 0;
  int total_checks = 0;
  int n;
  pss_row_type rows [8] = '{'{6'h00, 32'h0}, '{6'h08, 32'ha}, '{6'h0c, 32'ha}, '{6'h10, 32'h14},
    '{6'h14, 32'h96}, '{6'h18, 32'h64}, '{6'h28, 32'h0}, '{6'h3c, 32'h0}};
  pss_supervisor #(.TICK_CYCLES(4), .VALID_RST(16'h0014)) pss_supervisor_inst (.clk_i, .rst_i, .ce_i(1'b1),
    .bus_i, .rdata_o, .run_req_i, .flow_ok_i, .derag_din_i(1'b0), .trig_i, .speed_i, .run_o, .rev_o,
    .coast_o, .lube_o, .derag_dout_o, .verifying_o, .ext_status_o);
  pss_drive_model pss_drive_model_inst (.clk_i, .run_i(run_o), .flow_en_i(flow_en), .speed_o(speed_i),
    .flow_o(flow_ok_i));
  // Watched conditions for bounded waits
  assign obs = {coast_o, ext_status_o[0], ~ext_status_o[23], ext_status_o[3], ext_status_o[2], verifying_o, rev_o,
    lube_o, run_o};
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk_i);
    bus_i <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clk_i);
    bus_i <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    #1 d = rdata_o;
  endtask
  task automatic wt(input int b);
    for (n = 0; n < 400 && obs[b] !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n == 400) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic start();
    @(posedge clk_i);
    run_req_i <= 1'b1;
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 check("idle status", ext_status_o, 32'h0);
    foreach (rows[i]) begin
      rd(rows[i].a);
      check("register", d, rows[i].e);
    end
    $display("Test reset values done");
    // Derag from standstill on a sequence-logic pulse, output enabled
    wr(`PSS_A_CTRL, 32'h210);
    @(posedge clk_i);
    trig_i <= '{1'b1, 1'b0, 1'b0};
    @(posedge clk_i);
    trig_i <= '0;
    wt(2);
    check("derag status", ext_status_o, 32'h80_0000);
    check("derag output", 32'(derag_dout_o), 32'h1);
    wt(8);
    check("derag coast", 32'({coast_o, rev_o, derag_dout_o}), 32'h5);
    wt(6);
    @(posedge clk_i);
    #1 check("derag over", 32'({derag_dout_o, rev_o}), 32'h0);
    $display("Test derag done");
    // Pre-lube one second with half a second of start delay
    wr(`PSS_A_CTRL, 32'h1);
    wr(`PSS_A_SDLY, 32'h5);
    wr(`PSS_A_PRE, 32'h1);
    start();
    wt(1);
    check("stopped in delay", 32'(run_o), 32'h0);
    wt(0);
    check("lube over ramp", 32'(lube_o), 32'h1);
    repeat (30) @(posedge clk_i);
    #1 check("lube expired", 32'({lube_o, run_o}), 32'h1);
    @(posedge clk_i);
    run_req_i <= 1'b0;
    $display("Test lube done");
    // Start delay equal to time-to-speed must trip before running
    wr(`PSS_A_CTRL, 32'h4);
    wr(`PSS_A_TRIPSPD, 32'h10);
    wr(`PSS_A_SDLY, 32'ha);
    wr(`PSS_A_TTS, 32'ha);
    start();
    wt(5);
    check("speed trip", 32'({run_o, ext_status_o[3]}), 32'h1);
    @(posedge clk_i);
    run_req_i <= 1'b0;
    $display("Test speed trip done");
    // Flow lost inside the verification window
    wr(`PSS_A_CTRL, 32'h1008);
    wr(`PSS_A_SDLY, 32'h0);
    wr(`PSS_A_VERIF, 32'h8);
    start();
    wt(3);
    check("verifying", ext_status_o, 32'h2);
    @(posedge clk_i);
    flow_en <= 1'b1;
    repeat (8) @(posedge clk_i);
    flow_en <= 1'b0;
    wt(4);
    check("flow trip", 32'(ext_status_o[2]), 32'h1);
    @(posedge clk_i);
    run_req_i <= 1'b0;
    // Flow held through verification reaches normal running
    wr(`PSS_A_CTRL, 32'h1008);
    start();
    flow_en <= 1'b1;
    wt(7);
    check("running", 32'({ext_status_o[2], run_o}), 32'h1);
    $display("Test flow done");
    give_verdict();
  end
endmodule
